// ==== hw/lcd_cmd_device.sv ====
/*
 * command interpreter of a layered lcd controller with indirect addressing.
 * takes command and parameter bytes from the link, keeps cursor, direction,
 * pixel scroll and overlay state, and issues display memory writes.
 * a command byte always restarts decoding, so a cut parameter sequence
 * leaves the earlier state as it was; parameters with no command are dropped.
 * assumes the host orders bytes correctly and keeps the scroll procedure.
 * assumes bppMode changes only while no scroll parameter is in flight.
 * the memory side takes one write per cycle, as memWrite is never held.
 * the overlay output tells two layers from three; layer mixing lies elsewhere.
 */
// Decided for this implementation: register access over AXI4-Lite and the address map.
// How it works
// (RULE1) 46h loads two following bytes into cursor
// (RULE2) first byte low address, second byte high
// (RULE3) 4Ch sets direction right in bits 1-0
// (RULE4) 4Fh sets direction down, same field
// (RULE5) 42h bytes written at cursor, cursor advances
// (RULE6) pixel scroll bits 2-0 loaded by command
// (RULE7) host steps scroll, wraps, bumps start address
// (RULE8) rightward scroll is the reverse procedure
// (RULE9) host stops or redraws at virtual edge
// (RULE10) one scroll value shared by all layers
// (RULE11) no single-pixel scroll in 2/4 bpp
// (RULE12) overlay 1Ch selects three graphics layers
// (RULE13) overlay 00h selects text over graphics
// (RULE14) overlay 0Ch selects two graphics layers
`timescale 1ns/10ps
module lcd_cmd_device
    import lcd_cmd_pkg::*;
#(
    parameter logic [15:0] LINE_STRIDE = LINE_STRIDE_RST // bytes per line for up/down
) (
    input wire logic mclk, // system clock
    input wire logic srst, // sync reset, active high
    lcd_cmd_if.device link, // byte stream from host
    input wire logic [1:0] bppMode, // 0: 1bpp, 1: 2bpp, 2: 4bpp
    output logic memWrite, // one-cycle memory write strobe
    output logic [15:0] memAddr, // memory write address
    output logic [7:0] memData, // memory write data
    output logic [15:0] cursorAddr, // current cursor address
    output logic [1:0] cursorDir, // current shift direction
    output logic [2:0] pixelScroll, // scroll applied to all layers
    output logic [1:0] layerCount, // 2 or 3 active layers
    output logic firstIsText, // first layer shows text
    output logic overlayBad // last overlay value unsupported
);

    // decoder states: idle waits for a command, the others expect parameters
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CUR_LO = 3'b001,
        ST_CUR_HI = 3'b010,
        ST_DISPLAY_MEMORY_WRITE = 3'b011,
        ST_SCROLL = 3'b100,
        ST_OVERLAY = 3'b101
    } state_t;

    // all registered state, one packed record
    // filled by the comb process and registered by one flop process
    typedef struct packed {
        state_t st; // decoder state
        logic [15:0] cursor; // cursor address pair
        logic [7:0] curLow; // held low byte
        logic [1:0] dir; // auto-shift direction
        logic [2:0] hscroll; // pixel scroll value
        logic [7:0] overlay; // overlay parameter
        // the write port: strobe, address and data
        logic wr; // write strobe
        logic [15:0] wAddr; // write address
        logic [7:0] wData; // write data
    } regs_t;

    // state record and its next value
    regs_t cur; // current state
    regs_t next_cur; // next state
    logic take; // byte accepted this cycle

    // device always accepts: one byte per cycle
    // no back-pressure, so the host never holds a byte longer than one cycle
    assign link.ready = 1'b1;
    assign take = link.valid;

    // cursor step by direction
    // up and down move by one line; every direction wraps around the
    // 16-bit address space, keeping the cursor inside a layer is software's job
    function automatic logic [15:0] stepCursor(input logic [15:0] a, input logic [1:0] d);
        logic [15:0] r;
        // default keeps the address
        r = a;
        case (d)
            DIR_RIGHT: r = a + 16'h0001;
            DIR_LEFT: r = a - 16'h0001;
            DIR_UP: r = a - LINE_STRIDE;
            default: r = a + LINE_STRIDE;
        endcase
        return r;
    endfunction

    // next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.wr = 1'b0;
        if (take && link.isCmd) begin
            // a command byte always restarts decoding
            next_cur.st = ST_IDLE;
            // commands with parameters move to a waiting state,
            // direction codes only touch the two-bit field
            case (link.data)
                CMD_CURSOR_ADDR_WRITE: next_cur.st = ST_CUR_LO; // [RULE1]
                CMD_DIR_RIGHT: next_cur.dir = DIR_RIGHT; // [RULE3]
                CMD_DIR_LEFT: next_cur.dir = DIR_LEFT;
                CMD_DIR_UP: next_cur.dir = DIR_UP;
                CMD_DIR_DOWN: next_cur.dir = DIR_DOWN; // [RULE4]
                CMD_MEM_WRITE: next_cur.st = ST_DISPLAY_MEMORY_WRITE; // [RULE5]
                CMD_PIXEL_SCROLL: next_cur.st = ST_SCROLL; // [RULE6]
                CMD_LAYER_OVERLAY: next_cur.st = ST_OVERLAY;
                default: next_cur.st = ST_IDLE; // unknown code ignored
            endcase
        end else if (take) begin
            // parameter byte: its meaning depends on the last command
            case (cur.st)
                // first cursor byte is held until its partner arrives
                ST_CUR_LO: begin
                    next_cur.curLow = link.data; // [RULE2]
                    next_cur.st = ST_CUR_HI;
                end
                // second byte completes the pair in one update
                ST_CUR_HI: begin
                    next_cur.cursor = {link.data, cur.curLow}; // [RULE1] [RULE2]
                    next_cur.st = ST_IDLE;
                end
                ST_DISPLAY_MEMORY_WRITE: begin
                    // store at cursor then advance, stays for further bytes
                    next_cur.wr = 1'b1; // [RULE5]
                    next_cur.wAddr = cur.cursor;
                    next_cur.wData = link.data;
                    next_cur.cursor = stepCursor(cur.cursor, cur.dir); // [RULE5]
                end
                // one scroll parameter, then back to idle
                ST_SCROLL: begin
                    // fine steps only in 1bpp; other depths hold zero
                    if (bppMode == 2'h0) begin
                        next_cur.hscroll = link.data[HSCROLL_LSB +: HSCROLL_W]; // [RULE6]
                    end else begin
                        next_cur.hscroll = 3'h0; // [RULE11]
                    end
                    next_cur.st = ST_IDLE;
                end
                // overlay value kept even when unsupported, flagged below
                ST_OVERLAY: begin
                    next_cur.overlay = link.data; // [RULE12] [RULE13] [RULE14]
                    next_cur.st = ST_IDLE;
                end
                // a parameter with no command waiting is dropped
                default: next_cur.st = ST_IDLE; // stray parameter ignored
            endcase
        end
    end

    // state register, synchronous reset to constants only
    always_ff @(posedge mclk) begin
        if (srst) begin
            cur <= '{
                st: ST_IDLE, // decoder waits for a command
                cursor: CURSOR_RST, // cursor at start of memory
                curLow: 8'h00, // no low byte held
                dir: DIR_RIGHT, // shift rightward
                hscroll: 3'h0, // no pixel scroll
                overlay: OVERLAY_RST, // text over graphics
                wr: 1'b0, // no write pending
                wAddr: 16'h0000, // write address cleared
                wData: 8'h00 // write data cleared
            };
        end else begin
            cur <= next_cur;
        end
    end

    // outputs
    // memory write port: one-cycle strobe, address and data stand
    // until the next write so a slow sink may latch them late
    assign memWrite = cur.wr;
    assign memAddr = cur.wAddr;
    assign memData = cur.wData;
    // cursor state as the host left it
    assign cursorAddr = cur.cursor;
    assign cursorDir = cur.dir[DIR_LSB +: DIR_W];
    // deeper pixel modes force the shared scroll to zero at the output too,
    // so a value loaded in 1 bpp cannot leak after a mode change
    assign pixelScroll = (bppMode == 2'h0) ? cur.hscroll : 3'h0; // [RULE10] [RULE11]

    // overlay decode
    // two layers unless three graphics layers were chosen
    always_comb begin
        layerCount = 2'h2;
        firstIsText = 1'b0;
        overlayBad = 1'b0;
        if (cur.overlay == OVL_THREE_GFX) begin
            layerCount = 2'h3; // [RULE12]
        end else if (cur.overlay == OVL_TEXT_GFX) begin
            firstIsText = 1'b1; // [RULE13]
        end else if (cur.overlay == OVL_GFX_GFX) begin
            // both layers graphics
            firstIsText = 1'b0; // [RULE14]
        end else begin
            // unknown value: keep two layers and raise the flag
            overlayBad = 1'b1;
        end
    end
endmodule // lcd_cmd_device

// ==== hw/lcd_cmd_host.sv ====
/*
 * host end: axi4-lite slave whose registers let software queue command and
 * parameter bytes, and a smooth-scroll stepper that keeps the pixel scroll
 * value readable at HREG_SCROLL and drives start-address changes on startAddr. assumes device accepts via ready.
 */
`timescale 1ns/10ps
module lcd_cmd_host
    import lcd_cmd_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic srst, // sync reset, active high
    lcd_cmd_if.host link, // byte stream to device
    input wire logic [3:0] awaddr, // write address
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // byte enables
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // response valid
    input wire logic bready, // response ready
    input wire logic [3:0] araddr, // read address
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    output logic [15:0] startAddr // screen_block_start value kept by host
);
    // host state
    typedef struct packed {
        logic haveAw; // address captured
        logic haveW; // data captured
        logic [3:0] awa; // captured address
        logic [31:0] wd; // captured data
        logic [3:0] ws; // captured strobes
        logic bv; // response pending
        logic [1:0] br; // response code
        logic rv; // read data pending
        logic [31:0] rd; // read data
        logic [1:0] rr; // read response
        logic bv8; // byte pending on link
        logic cmd; // pending byte is command
        logic [7:0] byteVal; // pending byte
        logic [2:0] hs; // pixel scroll step
        logic [15:0] sa; // start address
    } hst_t;

    hst_t cur; // current state
    hst_t next_cur; // next state
    logic doWrite; // both halves held

    assign awready = !cur.haveAw && !cur.bv;
    assign wready = !cur.haveW && !cur.bv;
    assign arready = !cur.rv;
    assign doWrite = cur.haveAw && cur.haveW && !cur.bv;

    // register and link logic
    always_comb begin
        next_cur = cur;
        if (awvalid && awready) begin
            next_cur.haveAw = 1'b1;
            next_cur.awa = awaddr;
        end
        if (wvalid && wready) begin
            next_cur.haveW = 1'b1;
            next_cur.wd = wdata;
            next_cur.ws = wstrb;
        end
        if (link.valid && link.ready) begin
            next_cur.bv8 = 1'b0; // byte delivered
        end
        if (doWrite) begin
            next_cur.haveAw = 1'b0;
            next_cur.haveW = 1'b0;
            next_cur.bv = 1'b1;
            next_cur.br = RESP_OKAY;
            if (cur.awa == HREG_CMD) begin
                // bit 8 marks a command code; refused while a byte is pending
                if (cur.bv8 || !cur.ws[0]) begin
                    next_cur.br = RESP_SLVERR;
                end else begin
                    next_cur.bv8 = 1'b1;
                    next_cur.cmd = cur.wd[8];
                    next_cur.byteVal = cur.wd[7:0];
                end
            end else if (cur.awa == HREG_SCROLL) begin
                // one leftward or rightward pixel step, per bit 0
                if (cur.bv8) begin
                    next_cur.br = RESP_SLVERR;
                end else if (cur.wd[0] == 1'b0) begin
                    if (cur.hs == HSCROLL_MAX) begin
                        next_cur.hs = 3'h0; // [RULE7]
                        next_cur.sa = cur.sa + 16'h0001; // [RULE7]
                    end else begin
                        next_cur.hs = cur.hs + 3'h1; // [RULE7]
                    end
                end else begin
                    if (cur.hs == 3'h0) begin
                        next_cur.hs = HSCROLL_MAX; // [RULE8]
                        next_cur.sa = cur.sa - 16'h0001; // [RULE8]
                    end else begin
                        next_cur.hs = cur.hs - 3'h1; // [RULE8]
                    end
                end
            end else if (cur.awa == HREG_START) begin
                next_cur.sa = cur.wd[15:0]; // redraw or stop at edge is software's [RULE9]
            end else if (cur.awa != HREG_STATUS) begin
                next_cur.br = RESP_SLVERR;
            end
        end
        if (cur.bv && bready) begin
            next_cur.bv = 1'b0;
        end
        if (arvalid && arready) begin
            next_cur.rv = 1'b1;
            next_cur.rr = RESP_OKAY;
            next_cur.rd = 32'h00000000;
            if (araddr == HREG_STATUS) begin
                next_cur.rd = {31'h00000000, cur.bv8};
            end else if (araddr == HREG_SCROLL) begin
                next_cur.rd = {29'h00000000, cur.hs};
            end else if (araddr == HREG_START) begin
                next_cur.rd = {16'h0000, cur.sa};
            end else if (araddr != HREG_CMD) begin
                next_cur.rr = RESP_SLVERR;
            end
        end else if (cur.rv && rready) begin
            next_cur.rv = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign bvalid = cur.bv;
    assign bresp = cur.br;
    assign rvalid = cur.rv;
    assign rdata = cur.rd;
    assign rresp = cur.rr;
    assign link.valid = cur.bv8;
    assign link.isCmd = cur.cmd;
    assign link.data = cur.byteVal;
    assign startAddr = cur.sa;
endmodule // lcd_cmd_host

// ==== hw/lcd_cmd_if.sv ====
/*
 * byte link between host and command interpreter: a command/parameter
 * byte stream with valid/ready. assumes mclk is common to both ends.
 */
`timescale 1ns/10ps
interface lcd_cmd_if (
    input wire logic mclk // shared clock
);
    logic valid; // byte offered
    logic ready; // device takes byte
    logic isCmd; // byte is a command code
    logic [7:0] data; // byte value
    modport device (input valid, input isCmd, input data, output ready);
    modport host (output valid, output isCmd, output data, input ready);
endinterface

// ==== hw/lcd_cmd_pkg.sv ====
/*
 * shared constants for the layered lcd command interpreter and its host end:
 * command codes, overlay values, register field layouts and reset values.
 * assumes one clock (mclk) and a synchronous active-high reset on both ends.
 */
package lcd_cmd_pkg;
    // command codes
    localparam logic [7:0] CMD_CURSOR_ADDR_WRITE = 8'h46;
    localparam logic [7:0] CMD_DIR_RIGHT = 8'h4c;
    localparam logic [7:0] CMD_DIR_LEFT = 8'h4d;
    localparam logic [7:0] CMD_DIR_UP = 8'h4e;
    localparam logic [7:0] CMD_DIR_DOWN = 8'h4f;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
    localparam logic [7:0] CMD_PIXEL_SCROLL = 8'h5a;
    localparam logic [7:0] CMD_LAYER_OVERLAY = 8'h5b;
    // overlay configuration values
    localparam logic [7:0] OVL_TEXT_GFX = 8'h00;
    localparam logic [7:0] OVL_GFX_GFX = 8'h0c;
    localparam logic [7:0] OVL_THREE_GFX = 8'h1c;
    // direction field codes, bits 1-0 of cursor direction register
    localparam logic [1:0] DIR_RIGHT = 2'h0;
    localparam logic [1:0] DIR_LEFT = 2'h1;
    localparam logic [1:0] DIR_UP = 2'h2;
    localparam logic [1:0] DIR_DOWN = 2'h3;
    localparam int DIR_LSB = 0;
    localparam int DIR_W = 2;
    // pixel scroll field, bits 2-0
    localparam int HSCROLL_LSB = 0;
    localparam int HSCROLL_W = 3;
    localparam logic [2:0] HSCROLL_MAX = 3'h7;
    // reset values
    localparam logic [15:0] CURSOR_RST = 16'h0000;
    localparam logic [7:0] OVERLAY_RST = 8'h00;
    localparam logic [15:0] LINE_STRIDE_RST = 16'h0028;
    // host register map over axi4-lite (byte addresses)
    localparam logic [3:0] HREG_CMD = 4'h0;
    localparam logic [3:0] HREG_STATUS = 4'h4;
    localparam logic [3:0] HREG_SCROLL = 4'h8;
    localparam logic [3:0] HREG_START = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== sim/lcd_cmd_assertions.sv ====
/* checker for the host-device byte link and the device outputs.
   assumes one clock, sync reset and the default line stride. */
`timescale 1ns/10ps
module lcd_cmd_assertions
    import lcd_cmd_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic srst, // sync reset
    input wire logic valid, // byte offered
    input wire logic isCmd, // byte is a command
    input wire logic [7:0] data, // byte value
    input wire logic memWrite, // write strobe
    input wire logic [15:0] memAddr, // write address
    input wire logic [7:0] memData, // write data
    input wire logic [15:0] cursorAddr, // cursor
    input wire logic [1:0] cursorDir, // shift direction
    input wire logic [1:0] bppMode, // pixel depth
    input wire logic [2:0] pixelScroll, // scroll value
    input wire logic [1:0] layerCount, // active layers
    input wire logic firstIsText // text on first layer
);
    typedef struct packed {logic [7:0] cmd; logic [1:0] cnt; logic [7:0] low;} track_t;
    track_t trk, next_trk; // last command, parameter count, first parameter
    logic par; // parameter byte taken
    assign par = valid && !isCmd;
    // follow the byte stream
    always_comb begin
        next_trk = trk;
        if (valid && isCmd) begin
            next_trk.cmd = data;
            next_trk.cnt = 2'h0;
        end else if (par) begin
            if (trk.cnt == 2'h0) next_trk.low = data;
            if (trk.cnt != 2'h3) next_trk.cnt = trk.cnt + 2'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) trk <= '0;
        else trk <= next_trk;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence ovl_s(logic [7:0] v);
        par && trk.cmd == CMD_LAYER_OVERLAY && trk.cnt == 2'h0 && data == v;
    endsequence
    cursor_load_a: assert property (
        par && trk.cmd == CMD_CURSOR_ADDR_WRITE && trk.cnt == 2'h1 |=> cursorAddr == {$past(data), trk.low})
        else $error("cursor not loaded low then high");
    dir_right_a: assert property (valid && isCmd && data == CMD_DIR_RIGHT |=> cursorDir == DIR_RIGHT)
        else $error("direction not right");
    dir_down_a: assert property (valid && isCmd && data == CMD_DIR_DOWN |=> cursorDir == DIR_DOWN)
        else $error("direction not down");
    mem_source_a: assert property (
        memWrite |-> $past(par) && memData == $past(data) && trk.cmd == CMD_MEM_WRITE)
        else $error("memory write without its byte");
    step_right_a: assert property (memWrite && cursorDir == DIR_RIGHT |-> cursorAddr == memAddr + 16'h0001)
        else $error("cursor did not step right");
    step_down_a: assert property (memWrite && cursorDir == DIR_DOWN |-> cursorAddr == memAddr + LINE_STRIDE_RST)
        else $error("cursor did not step down");
    scroll_load_a: assert property (
        par && trk.cmd == CMD_PIXEL_SCROLL && trk.cnt == 2'h0 && bppMode == 2'h0
        |=> pixelScroll == $past(data[2:0])) else $error("scroll value not loaded");
    scroll_block_a: assert property (bppMode != 2'h0 && $stable(bppMode) |-> pixelScroll == 3'h0)
        else $error("pixel scroll in deep mode");
    three_layer_a: assert property (ovl_s(OVL_THREE_GFX) |=> layerCount == 2'h3)
        else $error("three layers not set");
    text_gfx_a: assert property (ovl_s(OVL_TEXT_GFX) |=> firstIsText && layerCount == 2'h2)
        else $error("text over graphics not set");
    gfx_gfx_a: assert property (ovl_s(OVL_GFX_GFX) |=> !firstIsText && layerCount == 2'h2)
        else $error("two graphics layers not set");
endmodule // lcd_cmd_assertions

// ==== sim/tb.sv ====
/* bench: software drives the host over axi4-lite, the host feeds the device.
   assumes one 50 MHz clock and a synchronous reset held 8 cycles. */
`timescale 1ns/10ps
module tb;
    import lcd_cmd_pkg::*;
    logic mclk = 1'b0, srst = 1'b1; // clock, reset
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0; // axi requests
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // handshakes
    logic [31:0] wdata = 32'h0, rdata; // data
    logic awready, wready, bvalid, arready, rvalid; // slave handshakes
    logic [1:0] bresp, rresp, bppMode = 2'h0, cursorDir, layerCount; // codes
    logic [15:0] startAddr, memAddr, cursorAddr, a, st; // addresses
    logic [7:0] memData; // write data
    logic memWrite, firstIsText, overlayBad; // flags
    logic [2:0] pixelScroll, s; // scroll
    logic [31:0] rnd, rd; // random and read values
    logic [1:0] r; // response
    logic [23:0] wrQ[$]; // seen memory writes
    int seed = 33124, n_fail = 0, check_count = 0;
    logic [7:0] ovl[4] = '{8'h00, 8'h0c, 8'h1c, 8'h33}; // overlay values
    logic [7:0] dirCmd[4] = '{CMD_DIR_RIGHT, CMD_DIR_LEFT, CMD_DIR_UP, CMD_DIR_DOWN}; // direction commands
    logic [1:0] dirCode[4] = '{DIR_RIGHT, DIR_LEFT, DIR_UP, DIR_DOWN}; // expected direction fields
    always #10 mclk = ~mclk;
    lcd_cmd_if lcd_cmd_if_i (.mclk);
    lcd_cmd_device lcd_cmd_device_i (.mclk, .srst, .link(lcd_cmd_if_i), .bppMode, .memWrite, .memAddr,
        .memData, .cursorAddr, .cursorDir, .pixelScroll, .layerCount, .firstIsText, .overlayBad);
    lcd_cmd_host lcd_cmd_host_i (.mclk, .srst, .link(lcd_cmd_if_i), .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .startAddr);
    lcd_cmd_assertions chk_i (.mclk, .srst, .valid(lcd_cmd_if_i.valid), .isCmd(lcd_cmd_if_i.isCmd),
        .data(lcd_cmd_if_i.data), .memWrite, .memAddr, .memData, .cursorAddr, .cursorDir, .bppMode,
        .pixelScroll, .layerCount, .firstIsText);
    // log every memory write
    always @(posedge mclk) if (memWrite === 1'b1) wrQ.push_back({memAddr, memData});
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // axi write: offer address and data together, wait for the response
    task automatic axiWrite(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] sb);
        int n;
        @(posedge mclk);
        awaddr <= ad; awvalid <= 1'b1; wdata <= d; wstrb <= sb; wvalid <= 1'b1; bready <= 1'b1;
        // loop test runs after each edge, once the requests just raised are visible
        n = 0;
        do begin
            @(posedge mclk);
            if (n > 200) begin n_fail++; wrap_up(); end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin r = bresp; bready <= 1'b0; end
            n++;
        end while (bready !== 1'b0 || awvalid || wvalid);
    endtask
    task automatic axiRead(input logic [3:0] ad);
        int n;
        @(posedge mclk);
        araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            if (n > 200) begin n_fail++; wrap_up(); end
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin rd = rdata; r = rresp; rready <= 1'b0; end
            n++;
        end while (rready !== 1'b0 || arvalid);
    endtask
    // one link byte, then wait until the host has passed it on
    task automatic sendByte(input logic c, input logic [7:0] b);
        int n;
        axiWrite(HREG_CMD, {23'h0, c, b}, 4'hf);
        check(32'(r), 32'(RESP_OKAY));
        rd = 32'h1;
        for (n = 0; rd[0] !== 1'b0; n++) begin
            if (n > 50) begin n_fail++; wrap_up(); end
            axiRead(HREG_STATUS);
        end
    endtask
    function automatic logic [15:0] nextCur(input logic [15:0] c, input logic [1:0] dr);
        if (dr == DIR_RIGHT) return c + 16'h0001;
        else if (dr == DIR_LEFT) return c - 16'h0001;
        else if (dr == DIR_UP) return c - LINE_STRIDE_RST;
        return c + LINE_STRIDE_RST;
    endfunction
    function automatic logic [3:0] expOvl(input logic [7:0] v);
        return {v == OVL_THREE_GFX ? 2'h3 : 2'h2, v == OVL_TEXT_GFX,
            !(v == OVL_TEXT_GFX || v == OVL_GFX_GFX || v == OVL_THREE_GFX)};
    endfunction
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        axiRead(HREG_START);
        check(rd, 32'h0); // start address resets to zero
        for (int i = 0; i < 3; i++) begin
            rnd = $random(seed);
            a = (i == 0) ? 16'h1001 : rnd[15:0];
            sendByte(1'b1, CMD_CURSOR_ADDR_WRITE);
            sendByte(1'b0, a[7:0]);
            sendByte(1'b0, a[15:8]);
            check(32'(cursorAddr), 32'(a));
        end
        for (int d = 0; d < 4; d++) begin
            sendByte(1'b1, dirCmd[d]);
            check(32'(cursorDir), 32'(dirCode[d]));
            sendByte(1'b1, CMD_MEM_WRITE);
            for (int k = 0; k < 4; k++) begin
                rnd = $random(seed);
                sendByte(1'b0, rnd[7:0]);
                check(32'(wrQ.size()), 32'h1);
                check(32'(wrQ.pop_front()), {8'h0, a, rnd[7:0]});
                a = nextCur(a, dirCode[d]);
            end
            check(32'(cursorAddr), 32'(a));
        end
        for (int m = 0; m < 3; m++) begin
            bppMode <= m[1:0];
            rnd = $random(seed);
            sendByte(1'b1, CMD_PIXEL_SCROLL);
            sendByte(1'b0, rnd[7:0] | 8'h01);
            check(32'(pixelScroll), m == 0 ? 32'(rnd[2:0] | 3'h1) : 32'h0);
        end
        bppMode <= 2'h0;
        foreach (ovl[i]) begin
            sendByte(1'b1, CMD_LAYER_OVERLAY);
            sendByte(1'b0, ovl[i]);
            check(32'({layerCount, firstIsText, overlayBad}), 32'(expOvl(ovl[i])));
        end
        rnd = $random(seed);
        st = rnd[15:0];
        s = 3'h0;
        axiWrite(HREG_START, {16'h0, st}, 4'hf);
        for (int k = 0; k < 24; k++) begin
            axiWrite(HREG_SCROLL, {31'h0, k >= 12}, 4'hf);
            if (k < 12) {st, s} = (s == HSCROLL_MAX) ? {st + 16'h1, 3'h0} : {st, s + 3'h1};
            else {st, s} = (s == 3'h0) ? {st - 16'h1, HSCROLL_MAX} : {st, s - 3'h1};
            axiRead(HREG_SCROLL);
            check(32'(rd[2:0]), 32'(s));
            check(32'(startAddr), 32'(st));
        end
        axiRead(4'h2);
        check(32'(r), 32'(RESP_SLVERR)); // unmapped read refused
        axiWrite(HREG_CMD, 32'h0000_0059, 4'he);
        check(32'(r), 32'(RESP_SLVERR)); // byte lane missing
        wrap_up();
    end
endmodule // tb
